// [hw/ecr_regs.svh]
`ifndef ECR_REGS_SVH
`define ECR_REGS_SVH

// read addresses on the serial slave port
`define ECR_ADDR_CONFIG_CHECKSUM      12'h060
`define ECR_ADDR_A_REAL      12'h1D0
`define ECR_ADDR_PHASE_A_APPARENT_ENERGY_CYCLE       12'h1D8
`define ECR_ADDR_B_REAL      12'h2BC
`define ECR_ADDR_PHASE_B_APPARENT_ENERGY_CYCLE       12'h2C4
`define ECR_ADDR_C_REAL      12'h3A8
`define ECR_ADDR_PHASE_C_APPARENT_ENERGY_CYCLE       12'h3B0
`define ECR_ADDR_NRMS        12'h840
// virtual command addresses
`define ECR_ADDR_PUSH_MIR    12'h900
`define ECR_ADDR_PULL_MIR    12'hA00
`define ECR_ADDR_FW_VERSION  12'hC00
`define ECR_ADDR_RAW_TEMP    12'hC01
`define ECR_ADDR_STOP        12'hC02
`define ECR_ADDR_LPM_ENTER   12'hC03
`define ECR_ADDR_LPM_EXIT    12'hC04

// reset and fill values
`define ECR_RESET_WORD       32'h0000_0000
`define ECR_RESET_HALF       16'h0000
`define ECR_DUMMY_DATA       32'h0000_0000

// energy scaling: full-scale product v*i sits at 2^30, one energy lsb is
// full-scale power over one processing cycle divided by 2^16
`define ECR_PROD_FS_SHIFT    30
`define ECR_ENERGY_FRAC      16
// neutral rms scaling: raw * coefficient / 2^16
`define ECR_NRMS_COEFF_SHIFT 16

`endif

// [hw/ecr_pkg.sv]
package ecr_pkg;

  typedef struct packed {
    logic [15:0] volt;       // signed instantaneous voltage
    logic [15:0] curr;       // signed instantaneous current
    logic [31:0] app_power;  // instantaneous apparent power, unsigned
  } ecr_phase_in_s;

  typedef struct packed {
    logic push_mirrors_to_hw;
    logic pull_hw_to_mirrors;
    logic start_temp;
    logic enter_stop;
  } ecr_cmd_s;

  typedef enum logic [1:0] {
    ECR_TEMP_IDLE,
    ECR_TEMP_FIRST,
    ECR_TEMP_SECOND
  } ecr_temp_e;

endpackage

// [hw/ecr_energy_phase.sv]
`include "ecr_regs.svh"

module ecr_energy_phase #(
  parameter int SAMPLES_LOG2 = 8,
  parameter int ACC_W        = 48
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rst_n,
  input  wire logic                  sample_valid,
  input  wire logic                  cycle_end,
  input  wire ecr_pkg::ecr_phase_in_s phase_in,
  output logic [31:0]                phase_real_energy_cycle,
  output logic [31:0]                phase_apparent_energy_cycle,
  output logic [ACC_W-1:0]           positive_energy_accumulator,
  output logic [ACC_W-1:0]           negative_energy_accumulator
);

  localparam int SHIFT = `ECR_PROD_FS_SHIFT - `ECR_ENERGY_FRAC
                         + SAMPLES_LOG2;

  typedef struct packed {
    logic [47:0]      real_sum;
    logic [47:0]      app_sum;
    logic [31:0]      real_e;
    logic [31:0]      app_e;
    logic [ACC_W-1:0] pos;
    logic [ACC_W-1:0] neg;
  } ecr_phase_state_s;

  ecr_phase_state_s q_reg;
  ecr_phase_state_s q_next;
  logic [31:0]      prod;
  logic [47:0]      real_now;
  logic [47:0]      app_now;
  logic [47:0]      real_shift;
  logic [47:0]      app_shift;
  logic [31:0]      real_mag;

  ////////////////////////////////////////////////////////////////////////
  assign prod = $signed(phase_in.volt) * $signed(phase_in.curr);
  // the closing sample still counts in the cycle it ends
  assign real_now = sample_valid ? q_reg.real_sum + {{16{prod[31]}}, prod}
                                 : q_reg.real_sum;
  assign app_now  = sample_valid ? q_reg.app_sum + {16'h0000,
                                   phase_in.app_power} : q_reg.app_sum;
  assign real_shift = $signed(real_now) >>> SHIFT;
  assign app_shift  = $signed(app_now) >>> SHIFT;
  assign real_mag   = real_shift[31] ? 32'(-real_shift[31:0])
                                     : real_shift[31:0];

  always_comb begin
    q_next          = q_reg;
    q_next.real_sum = real_now;
    q_next.app_sum  = app_now;
    if (cycle_end) begin
      q_next.real_sum = 48'h0000_0000_0000;
      q_next.app_sum  = 48'h0000_0000_0000;
      q_next.real_e   = real_shift[31:0];
      q_next.app_e    = app_shift[31:0];
      if (!real_shift[31]) begin
        q_next.pos = q_reg.pos + ACC_W'(real_mag);
      end else begin
        q_next.neg = q_reg.neg + ACC_W'(real_mag);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

  assign phase_real_energy_cycle     = q_reg.real_e;
  assign phase_apparent_energy_cycle = q_reg.app_e;
  assign positive_energy_accumulator = q_reg.pos;
  assign negative_energy_accumulator = q_reg.neg;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_real_capture: assert property (
    cycle_end |=> phase_real_energy_cycle == $past(real_shift[31:0]))
    else $error("real energy not captured at cycle end");
  phase_a_apparent_energy_cycle_capture: assert property (
    cycle_end |=> phase_apparent_energy_cycle == $past(app_shift[31:0]))
    else $error("apparent energy not captured at cycle end");
  a_sign_split: assert property (
    cycle_end && !real_shift[31] |=> $stable(negative_energy_accumulator)
      && positive_energy_accumulator == $past(q_next.pos))
    else $error("non-negative energy went to wrong accumulator");
  a_sum_restart: assert property (
    cycle_end ##1 !sample_valid |=> q_reg.real_sum == 48'h0000_0000_0000)
    else $error("running sum not restarted");

endmodule

// [hw/ecr_result_regs.sv]
`include "ecr_regs.svh"

// Behaviour
// - each phase has a signed register for the last cycle's real energy.
// - instantaneous v*i is added into a running sum once per sample period.
// - cycle end latches the sum and adds it to the accumulator of its sign.
// - one energy lsb is full-scale v times i times cycle time over 2^16.
// - each phase has an unsigned register for the last cycle's apparent energy.
// - a 16-bit additive checksum over the configuration words is readable.
// - the checksum is recomputed and refreshed once every processing cycle.
// - a changed checksum value sets the checksum-changed flag.
// - sum covers clock, coeffs, mirrors, gains, limits, timeouts, pulse cfg.
// - neutral rms current is reported scaled by the current coefficient.
// - virtual address reads trigger special commands, some with dummy data.
// - two virtual reads copy mirrors to hardware or back, with dummy data.
// - one read gives firmware version; the next averages two temperatures.
// - three reads enter stop mode, enter and leave reduced power mode.
module ecr_result_regs #(
  parameter int          CFG_WORDS    = 58,
  parameter int          SAMPLES_LOG2 = 8,
  parameter int          ACC_W        = 48,
  parameter logic [15:0] FW_VERSION   = 16'h0101 // arbitrary value
) (
  input  wire logic                        sys_clk,
  input  wire logic                        rst_n,
  input  wire logic                        sample_valid,
  input  wire logic                        cycle_end,
  input  wire ecr_pkg::ecr_phase_in_s [2:0] phase_in,
  input  wire logic [CFG_WORDS-1:0][15:0]  cfg_words,
  input  wire logic [31:0]                 neutral_rms_raw,
  input  wire logic [15:0]                 current_conversion_coeff,
  input  wire logic                        temp_valid,
  input  wire logic [15:0]                 temp_sample,
  input  wire logic                        rd_req,
  input  wire logic [11:0]                 rd_addr,
  output logic [31:0]                      rd_data,
  output logic                             rd_valid,
  input  wire logic                        flag_clear,
  output logic                             checksum_changed_flag,
  output ecr_pkg::ecr_cmd_s                cmd,
  output logic                             reduced_power_mode,
  output logic [2:0][ACC_W-1:0]            positive_energy_accumulator,
  output logic [2:0][ACC_W-1:0]            negative_energy_accumulator
);

  typedef struct packed {
    logic [15:0]       chk;
    logic              chk_valid;
    logic              flag;
    logic [31:0]       nrms;
    logic [31:0]       rd_data;
    logic              rd_valid;
    ecr_pkg::ecr_cmd_s cmd;
    logic              lpm;
    ecr_pkg::ecr_temp_e temp_st;
    logic [15:0]       temp_first;
    logic [15:0]       temp_result;
  } ecr_top_state_s;

  ecr_top_state_s q_reg;
  ecr_top_state_s q_next;
  logic [2:0][31:0] real_e;
  logic [2:0][31:0] app_e;
  logic [15:0]      chk_sum;
  logic             chk_set;
  logic [47:0]      nrms_prod;
  logic [31:0]      nrms_scaled;
  logic [16:0]      temp_sum;

  ////////////////////////////////////////////////////////////////////////
  // one instance per phase; accumulators live beside the cycle results
  for (genvar p = 0; p < 3; p++) begin : g_phase
    ecr_energy_phase #(
      .SAMPLES_LOG2 (SAMPLES_LOG2),
      .ACC_W        (ACC_W)
    ) u_phase (
      .sys_clk                     (sys_clk),
      .rst_n                       (rst_n),
      .sample_valid                (sample_valid),
      .cycle_end                   (cycle_end),
      .phase_in                    (phase_in[p]),
      .phase_real_energy_cycle     (real_e[p]),
      .phase_apparent_energy_cycle (app_e[p]),
      .positive_energy_accumulator (positive_energy_accumulator[p]),
      .negative_energy_accumulator (negative_energy_accumulator[p])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // additive sum, wraps mod 2^16; the coverage list is whatever the
  // integrator wires into cfg_words, in any order
  always_comb begin
    chk_sum = `ECR_RESET_HALF;
    for (int k = 0; k < CFG_WORDS; k++) begin
      chk_sum = chk_sum + cfg_words[k];
    end
  end

  assign nrms_prod   = {16'h0000, neutral_rms_raw}
                       * {32'h0000_0000, current_conversion_coeff};
  assign nrms_scaled = nrms_prod[`ECR_NRMS_COEFF_SHIFT+31:
                                 `ECR_NRMS_COEFF_SHIFT];
  assign temp_sum    = {1'b0, q_reg.temp_first} + {1'b0, temp_sample};

  always_comb begin
    q_next          = q_reg;
    q_next.cmd      = '0;
    q_next.rd_valid = rd_req;
    // first computation after reset has nothing to differ from
    chk_set = cycle_end && q_reg.chk_valid && (chk_sum != q_reg.chk);
    if (cycle_end) begin
      q_next.chk       = chk_sum;
      q_next.chk_valid = 1'b1;
      q_next.nrms      = nrms_scaled;
    end
    // a change in the clearing cycle is not lost
    q_next.flag = (q_reg.flag & ~flag_clear) | chk_set;
    case (q_reg.temp_st)
      ecr_pkg::ECR_TEMP_FIRST: begin
        if (temp_valid) begin
          q_next.temp_first = temp_sample;
          q_next.temp_st    = ecr_pkg::ECR_TEMP_SECOND;
        end
      end
      ecr_pkg::ECR_TEMP_SECOND: begin
        if (temp_valid) begin
          q_next.temp_result = temp_sum[16:1];
          q_next.temp_st     = ecr_pkg::ECR_TEMP_IDLE;
        end
      end
      default: begin
      end
    endcase
    if (rd_req) begin
      case (rd_addr)
        `ECR_ADDR_CONFIG_CHECKSUM:  q_next.rd_data = {16'h0000, q_reg.chk};
        `ECR_ADDR_A_REAL:  q_next.rd_data = real_e[0];
        `ECR_ADDR_PHASE_A_APPARENT_ENERGY_CYCLE:   q_next.rd_data = app_e[0];
        `ECR_ADDR_B_REAL:  q_next.rd_data = real_e[1];
        `ECR_ADDR_PHASE_B_APPARENT_ENERGY_CYCLE:   q_next.rd_data = app_e[1];
        `ECR_ADDR_C_REAL:  q_next.rd_data = real_e[2];
        `ECR_ADDR_PHASE_C_APPARENT_ENERGY_CYCLE:   q_next.rd_data = app_e[2];
        `ECR_ADDR_NRMS:    q_next.rd_data = q_reg.nrms;
        `ECR_ADDR_PUSH_MIR: begin
          q_next.rd_data                = `ECR_DUMMY_DATA;
          q_next.cmd.push_mirrors_to_hw = 1'b1;
        end
        `ECR_ADDR_PULL_MIR: begin
          q_next.rd_data                = `ECR_DUMMY_DATA;
          q_next.cmd.pull_hw_to_mirrors = 1'b1;
        end
        `ECR_ADDR_FW_VERSION: begin
          q_next.rd_data = {16'h0000, FW_VERSION};
        end
        `ECR_ADDR_RAW_TEMP: begin
          // returns the last average; a read mid-average restarts it
          q_next.rd_data        = {16'h0000, q_reg.temp_result};
          q_next.cmd.start_temp = 1'b1;
          q_next.temp_st        = ecr_pkg::ECR_TEMP_FIRST;
        end
        `ECR_ADDR_STOP: begin
          q_next.rd_data        = `ECR_DUMMY_DATA;
          q_next.cmd.enter_stop = 1'b1;
        end
        `ECR_ADDR_LPM_ENTER: begin
          q_next.rd_data = `ECR_DUMMY_DATA;
          q_next.lpm     = 1'b1;
        end
        `ECR_ADDR_LPM_EXIT: begin
          q_next.rd_data = `ECR_DUMMY_DATA;
          q_next.lpm     = 1'b0;
        end
        default: q_next.rd_data = `ECR_DUMMY_DATA;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

  assign rd_data               = q_reg.rd_data;
  assign rd_valid              = q_reg.rd_valid;
  assign checksum_changed_flag = q_reg.flag;
  assign cmd                   = q_reg.cmd;
  assign reduced_power_mode    = q_reg.lpm;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_read(logic [11:0] a);
    rd_req && rd_addr == a;
  endsequence

  sequence s_second_sample;
    q_reg.temp_st == ecr_pkg::ECR_TEMP_SECOND && temp_valid && !rd_req;
  endsequence

  a_chk_refresh: assert property (
    cycle_end |=> q_reg.chk == $past(chk_sum) && q_reg.chk_valid)
    else $error("checksum not refreshed at cycle end");
  a_flag_set: assert property (
    cycle_end && q_reg.chk_valid && chk_sum != q_reg.chk
      |=> checksum_changed_flag)
    else $error("checksum change did not set flag");
  a_flag_sticky: assert property (
    checksum_changed_flag && !flag_clear |=> checksum_changed_flag)
    else $error("checksum flag dropped without clear");
  a_read_answer: assert property (
    rd_req |=> rd_valid ##1 (rd_valid == $past(rd_req)))
    else $error("read answer not one cycle after request");
  a_nrms_read: assert property (
    s_read(`ECR_ADDR_NRMS) |=> rd_data == $past(q_reg.nrms))
    else $error("neutral rms read wrong");
  a_push_dummy: assert property (
    s_read(`ECR_ADDR_PUSH_MIR) |=> cmd.push_mirrors_to_hw
      && rd_data == `ECR_DUMMY_DATA ##1 !cmd.push_mirrors_to_hw)
    else $error("push command not a single pulse with dummy data");
  a_temp_average: assert property (
    s_second_sample |=> q_reg.temp_result == $past(temp_sum[16:1])
      && q_reg.temp_st == ecr_pkg::ECR_TEMP_IDLE)
    else $error("temperature average wrong");
  a_lpm_enter: assert property (
    s_read(`ECR_ADDR_LPM_ENTER) |=> reduced_power_mode)
    else $error("reduced power mode not entered on read");
  a_lpm_exit: assert property (
    s_read(`ECR_ADDR_LPM_EXIT) |=> !reduced_power_mode)
    else $error("reduced power mode not left on read");
  a_stop_pulse: assert property (
    s_read(`ECR_ADDR_STOP) |=> cmd.enter_stop ##1 !cmd.enter_stop)
    else $error("stop command not a single pulse");

endmodule

// [verif/ecr_host_model.sv]
`include "ecr_regs.svh"

module ecr_host_model (
  input  wire logic        sys_clk,
  input  wire logic        rd_valid,
  input  wire logic [31:0] rd_data,
  output logic             rd_req,
  output logic [11:0]      rd_addr
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] chk_rec;
  logic        chk_have;

  initial begin
    rd_req   = 1'b0;
    rd_addr  = 12'h000;
    chk_rec  = 16'h0000;
    chk_have = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // one-cycle request; answer sampled once the answering edge has settled
  task automatic read_word(input logic [11:0] a, output logic [31:0] d,
                           output logic ok);
    @(posedge sys_clk);
    rd_req  <= 1'b1;
    rd_addr <= a;
    @(posedge sys_clk);
    rd_req  <= 1'b0;
    // a stale address would hide a design that samples late
    rd_addr <= ~a;
    #1;
    ok = rd_valid;
    d  = rd_data;
  endtask

  // record once, then compare every later poll against the record
  task automatic poll_checksum(output logic changed);
    logic [31:0] d;
    logic        ok;
    read_word(`ECR_ADDR_CONFIG_CHECKSUM, d, ok);
    changed = chk_have && (d[15:0] !== chk_rec);
    if (!chk_have) begin
      chk_rec = d[15:0];
    end
    chk_have = 1'b1;
  endtask
endmodule

// [verif/energy_checksum_result_regs_tb.sv]
`include "ecr_regs.svh"

module energy_checksum_result_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int          CW = 4;
  localparam int          SL = 2;
  localparam int          SH = 14 + SL;
  localparam logic [15:0] FW = 16'h5A3C; // arbitrary value
  localparam logic [11:0] A_REAL [3] = '{`ECR_ADDR_A_REAL,
    `ECR_ADDR_B_REAL, `ECR_ADDR_C_REAL};
  localparam logic [11:0] PHASE_A_APPARENT_ENERGY_CYCLE [3] = '{`ECR_ADDR_PHASE_A_APPARENT_ENERGY_CYCLE,
    `ECR_ADDR_PHASE_B_APPARENT_ENERGY_CYCLE, `ECR_ADDR_PHASE_C_APPARENT_ENERGY_CYCLE};
  localparam logic [11:0] C_ADDR [5] = '{`ECR_ADDR_PUSH_MIR,
    `ECR_ADDR_PULL_MIR, `ECR_ADDR_STOP, `ECR_ADDR_LPM_ENTER,
    `ECR_ADDR_LPM_EXIT};
  localparam logic [3:0]  C_CMD [5] = '{4'h8, 4'h4, 4'h1, 4'h0, 4'h0};
  localparam logic        C_LPM [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
  localparam int          NS [3] = '{4, 1, 5};

  logic                         sys_clk;
  logic                         rst_n;
  logic                         sample_valid;
  logic                         cycle_end;
  logic                         temp_valid;
  logic                         flag_clear;
  logic                         rd_req;
  logic                         rd_valid;
  logic                         checksum_changed_flag;
  logic                         reduced_power_mode;
  logic [11:0]                  rd_addr;
  logic [31:0]                  rd_data;
  logic [31:0]                  neutral_rms_raw;
  logic [15:0]                  current_conversion_coeff;
  logic [15:0]                  temp_sample;
  logic [CW-1:0][15:0]          cfg_words;
  ecr_pkg::ecr_phase_in_s [2:0] phase_in;
  ecr_pkg::ecr_cmd_s            cmd;
  logic [2:0][47:0]             pos_acc;
  logic [2:0][47:0]             neg_acc;
  logic [15:0]                  m_chk;
  logic                         m_flag;
  logic                         m_have;
  logic [15:0]                  m_rec;
  logic                         m_rec_ok;
  logic [31:0]                  m_nrms;
  longint                       m_real [3];
  longint                       m_app [3];
  longint                       m_pos [3];
  longint                       m_neg [3];
  int                           n_fail;
  int                           n_compared;
  int                           seed;
  int                           cyc;

  ecr_result_regs #(.CFG_WORDS(CW), .SAMPLES_LOG2(SL), .ACC_W(48),
    .FW_VERSION(FW)) dut_u (
    .sys_clk(sys_clk), .rst_n(rst_n), .sample_valid(sample_valid),
    .cycle_end(cycle_end), .phase_in(phase_in), .cfg_words(cfg_words),
    .neutral_rms_raw(neutral_rms_raw),
    .current_conversion_coeff(current_conversion_coeff),
    .temp_valid(temp_valid), .temp_sample(temp_sample), .rd_req(rd_req),
    .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid),
    .flag_clear(flag_clear), .checksum_changed_flag(checksum_changed_flag),
    .cmd(cmd), .reduced_power_mode(reduced_power_mode),
    .positive_energy_accumulator(pos_acc),
    .negative_energy_accumulator(neg_acc));

  ecr_host_model host_u (.sys_clk(sys_clk), .rd_valid(rd_valid),
    .rd_data(rd_data), .rd_req(rd_req), .rd_addr(rd_addr));

  ////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // hang guard; a full run needs well under a thousand cycles
  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic run_cycle(input int ns);
    ecr_pkg::ecr_phase_in_s [2:0] pin;
    longint                       sr [3];
    longint                       sa [3];
    logic signed [31:0]           e32;
    logic [15:0]                  c16;
    sr = '{0, 0, 0};
    sa = '{0, 0, 0};
    for (int k = 0; k < ns; k++) begin
      for (int p = 0; p < 3; p++) begin
        pin[p] = {$random(seed), $random(seed)};
        sr[p] += longint'($signed(pin[p].volt)) * $signed(pin[p].curr);
        sa[p] += longint'(pin[p].app_power);
      end
      @(posedge sys_clk);
      phase_in     <= pin;
      sample_valid <= 1'b1;
      cycle_end    <= (k == ns - 1);
    end
    @(posedge sys_clk);
    sample_valid <= 1'b0;
    cycle_end    <= 1'b0;
    for (int p = 0; p < 3; p++) begin
      e32 = 32'(sr[p] >>> SH);
      m_real[p] = e32;
      m_app[p] = sa[p] >> SH;
      if (e32 >= 0) begin
        m_pos[p] += e32;
      end else begin
        m_neg[p] -= e32;
      end
    end
    c16 = 16'h0000;
    for (int w = 0; w < CW; w++) begin
      c16 += cfg_words[w];
    end
    if (m_have && c16 !== m_chk) begin
      m_flag = 1'b1;
    end
    m_chk = c16;
    m_have = 1'b1;
    m_nrms = 32'((longint'(neutral_rms_raw) * current_conversion_coeff)
                 >> 16);
  endtask

  task automatic check_results();
    logic [31:0] d;
    logic        ok;
    logic        ch;
    for (int p = 0; p < 3; p++) begin
      host_u.read_word(A_REAL[p], d, ok);
      check(ok, 1'b1);
      check(d, m_real[p][31:0]);
      host_u.read_word(PHASE_A_APPARENT_ENERGY_CYCLE[p], d, ok);
      check(d, m_app[p][31:0]);
      check(pos_acc[p], m_pos[p][47:0]);
      check(neg_acc[p], m_neg[p][47:0]);
    end
    host_u.read_word(`ECR_ADDR_CONFIG_CHECKSUM, d, ok);
    check(d, {16'h0000, m_chk});
    check(checksum_changed_flag, m_flag);
    host_u.read_word(`ECR_ADDR_NRMS, d, ok);
    check(d, m_nrms);
    host_u.poll_checksum(ch);
    check(ch, m_rec_ok && m_chk != m_rec);
    if (!m_rec_ok) begin
      m_rec = m_chk;
    end
    m_rec_ok = 1'b1;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d;
    logic        ok;
    logic [15:0] ts [2];
    seed = 32'h14fe;
    n_fail = 0;
    n_compared = 0;
    cyc = 0;
    m_chk = 16'h0000;
    m_flag = 1'b0;
    m_have = 1'b0;
    m_rec = 16'h0000;
    m_rec_ok = 1'b0;
    rst_n = 1'b0;
    sample_valid = 1'b0;
    cycle_end = 1'b0;
    temp_valid = 1'b0;
    flag_clear = 1'b0;
    temp_sample = 16'h0000;
    cfg_words = '0;
    phase_in = '0;
    neutral_rms_raw = 32'h0000_0000;
    current_conversion_coeff = 16'h0000;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1;
    check({rd_data, checksum_changed_flag, cmd, reduced_power_mode}, 0);
    $display("reset test done");
    for (int i = 0; i < 3; i++) begin
      @(posedge sys_clk);
      // the last cycle keeps its words so the flag must stay up
      if (i < 2) begin
        cfg_words <= {$random(seed), $random(seed)};
      end
      neutral_rms_raw <= $random(seed);
      current_conversion_coeff <= 16'($random(seed));
      run_cycle(NS[i]);
      check_results();
      $display("energy cycle %0d test done", i);
    end
    @(posedge sys_clk);
    flag_clear <= 1'b1;
    @(posedge sys_clk);
    flag_clear <= 1'b0;
    #1;
    check(checksum_changed_flag, 1'b0);
    for (int i = 0; i < 5; i++) begin
      host_u.read_word(C_ADDR[i], d, ok);
      check(d, 32'h0);
      check({cmd, reduced_power_mode}, {C_CMD[i], C_LPM[i]});
    end
    host_u.read_word(`ECR_ADDR_FW_VERSION, d, ok);
    check(d, {16'h0000, FW});
    host_u.read_word(12'h123, d, ok);
    check({ok, d}, {1'b1, 32'h0});
    $display("command test done");
    host_u.read_word(`ECR_ADDR_RAW_TEMP, d, ok);
    check({d, cmd}, {32'h0, 4'h2});
    for (int k = 0; k < 2; k++) begin
      ts[k] = 16'($random(seed));
      repeat (3) @(posedge sys_clk);
      temp_valid  <= 1'b1;
      temp_sample <= ts[k];
      @(posedge sys_clk);
      temp_valid  <= 1'b0;
      temp_sample <= ~ts[k];
    end
    host_u.read_word(`ECR_ADDR_RAW_TEMP, d, ok);
    check(d, 32'((17'(ts[0]) + ts[1]) >> 1));
    $display("temperature test done");
    complete_run();
  end
endmodule
